// *** dv/acc_channel_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_channel_ctrl_bench
  import acc_pkg::*;
;
  logic sys_clk = 0;
  logic reset_n = 0;
  logic wr_valid = 0;
  logic meas_start = 0;
  logic comp_in = 0;
  logic lk = 0;
  logic pend, cen, csi;
  logic [3:0] caux;
  logic [31:0] a;
  acc_ctrl_t wr_data = ACC_CTRL_RESET;
  acc_ctrl_t img, e;
  acc_result_t res;
  int n_fail = 0;
  int n_tests = 0;
  int i;
  integer seed = 32'h81AB;
  // Free-running clock.
  always #2 sys_clk = ~sys_clk;
  acc_channel_ctrl #(.SYNC_CYCLES(4)) acc_channel_ctrl_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .wr_valid(wr_valid), .wr_data(wr_data),
    .channel_control_reg(img), .sync_pending_flags(pend), .comp_enable(cen),
    .comp_single(csi), .comp_aux(caux), .meas_start(meas_start), .comp_in(comp_in),
    .comp_result(res)
  );
  // Expected image: while locked only the enable bit gets through.
  function automatic acc_ctrl_t nxt(acc_ctrl_t o, acc_ctrl_t w, logic l);
    nxt = l ? o : w;
    nxt.enable = w.enable;
    nxt.reserved0 = 1'b0;
  endfunction
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      n_fail++;
    end
  endtask
  // Reserved bit is driven high on purpose so that its readback is exercised.
  task automatic wr(input logic en, input logic s, input logic [3:0] x);
    @(negedge sys_clk);
    wr_valid = 1;
    wr_data = {x, s, en, 1'b1};
    e = nxt(e, wr_data, lk);
    lk = lk | en;
    @(negedge sys_clk);
    wr_valid = 0;
    chk("image", {1'b0, e}, {1'b0, img});
    chk("pending", 8'h01, {7'h00, pend});
  endtask
  // Bounded wait for the crossing to finish, then check the core side.
  task automatic settle;
    for (i = 0; i < 20 && pend !== 1'b0; i++)
      @(negedge sys_clk);
    if (i == 20)
    begin
      n_fail++;
      close_out;
    end
    else
    begin
      chk("core", {7'h00, e.enable}, {7'h00, cen});
      chk("aux", {4'h0, e.aux}, {4'h0, caux});
    end
    if (!e.enable)
      lk = 0;
  endtask
  initial
  begin
    e = ACC_CTRL_RESET;
    repeat (20) @(negedge sys_clk);
    reset_n = 1;
    @(negedge sys_clk);
    chk("reset", 8'h00, {pend, img});
    chk("reset_core", 8'h00, {cen, csi, caux, res});
    repeat (6)
    begin
      a = $random(seed);
      wr(0, a[4], a[3:0]);
      settle;
    end
    comp_in = 1;
    wr(1, 1, 4'hA);
    chk("early", 8'h00, {7'h00, cen});
    wr(1, 0, 4'h5);
    settle;
    chk("single", 8'h01, {7'h00, csi});
    @(negedge sys_clk);
    meas_start = 1;
    @(negedge sys_clk);
    meas_start = 0;
    @(negedge sys_clk);
    chk("shot", 8'h03, {6'h00, res});
    wr(0, 0, 4'h3);
    wr(0, 0, 4'hC);
    settle;
    wr(1, 0, 4'h6);
    settle;
    comp_in = 0;
    // A continuous result that never shows up is a failure, not a hang.
    for (i = 0; i < 20 && res.valid !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 20)
    begin
      n_fail++;
      close_out;
    end
    else
    begin
      chk("cont", 8'h01, {6'h00, res});
    end
    wr(0, 1, 4'h9);
    settle;
    close_out;
  end
endmodule
`default_nettype wire

// *** dv/acc_channel_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_channel_ctrl_chk
  import acc_pkg::*;
#(
  parameter int SYNC_CYCLES = ACC_SYNC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_valid,
  input wire acc_ctrl_t wr_data,
  input wire acc_ctrl_t channel_control_reg,
  input wire logic sync_pending_flags,
  input wire logic comp_enable,
  input wire logic comp_single,
  input wire logic meas_start,
  input wire acc_result_t comp_result
);
  logic [7:0] q_q;
  logic [7:0] q_d;
  // Cycles since the last write; it saturates so that idle time never looks like a fresh write.
  assign q_d = wr_valid ? 8'h01 : ((q_q == 8'hFF) ? q_q : q_q + 8'h01);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      q_q <= 8'hFF;
    else
      q_q <= q_d;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // A start request that the core is free to take.
  sequence s_shot;
    meas_start && comp_enable && comp_single && !comp_result.valid && !$past(meas_start);
  endsequence
  property p_rst;
    $rose(reset_n) |-> channel_control_reg == ACC_CTRL_RESET && !sync_pending_flags && !comp_enable;
  endproperty
  property p_read;
    wr_valid |=> channel_control_reg.enable == $past(wr_data.enable) && sync_pending_flags;
  endproperty
  property p_slow;
    wr_valid && !sync_pending_flags && !comp_enable |=> !comp_enable;
  endproperty
  property p_wait;
    q_q == SYNC_CYCLES |-> sync_pending_flags;
  endproperty
  property p_done;
    q_q == SYNC_CYCLES + 1 |-> !sync_pending_flags && comp_enable == channel_control_reg.enable;
  endproperty
  property p_lock;
    wr_valid && channel_control_reg.enable |=> $stable(channel_control_reg.single) &&
      $stable(channel_control_reg.aux);
  endproperty
  property p_free;
    wr_valid && !channel_control_reg.enable && !sync_pending_flags && !comp_enable
      |=> channel_control_reg.single == $past(wr_data.single);
  endproperty
  // The mode bit may only move while the channel is fully off.
  property p_mode;
    $changed(comp_single) |-> !$past(channel_control_reg.enable) && !$past(comp_enable);
  endproperty
  property p_shot;
    s_shot |-> ##2 comp_result.valid ##1 !comp_result.valid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_read: assert property (p_read) else $error("readback or pending wrong");
  a_slow: assert property (p_slow) else $error("core switched too early");
  a_wait: assert property (p_wait) else $error("pending cleared early");
  a_done: assert property (p_done) else $error("core did not follow");
  a_lock: assert property (p_lock) else $error("locked bits changed");
  a_free: assert property (p_free) else $error("unlocked write lost");
  a_mode: assert property (p_mode) else $error("mode bit changed while enabled");
  a_shot: assert property (p_shot) else $error("one-shot result missing");
endmodule
bind acc_channel_ctrl acc_channel_ctrl_chk #(.SYNC_CYCLES(SYNC_CYCLES)) acc_channel_ctrl_chk_i (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .wr_valid(wr_valid),
  .wr_data(wr_data),
  .channel_control_reg(channel_control_reg),
  .sync_pending_flags(sync_pending_flags),
  .comp_enable(comp_enable),
  .comp_single(comp_single),
  .meas_start(meas_start),
  .comp_result(comp_result)
);
`default_nettype wire

// *** rtl/acc_channel_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module acc_channel_ctrl
  import acc_pkg::*;
#(
  parameter int SYNC_CYCLES = ACC_SYNC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_valid,
  input wire acc_ctrl_t wr_data,
  output acc_ctrl_t channel_control_reg,
  output logic sync_pending_flags,
  output logic comp_enable,
  output logic comp_single,
  output logic [ACC_AUX_W-1:0] comp_aux,
  input wire logic meas_start,
  input wire logic comp_in,
  output acc_result_t comp_result
);

  localparam int CNT_W = $clog2(SYNC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SYNC_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  acc_ctrl_t ctrl_q;
  acc_ctrl_t ctrl_d;
  acc_ch_state_t state_q;
  acc_ch_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic pending_q;
  logic pending_d;
  logic lock_q;
  logic lock_d;
  logic core_en_q;
  logic core_en_d;
  logic armed_q;
  logic armed_d;
  acc_result_t result_q;
  acc_result_t result_d;
  logic cmp_level;

  // The comparator pin is asynchronous, so it is filtered before use.
  acc_pin_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in(comp_in),
    .level_out(cmp_level)
  );

  // Write decoding kept as named wires.
  wire syncing = (state_q == ACC_CH_SYNC_ON) || (state_q == ACC_CH_SYNC_OFF);
  wire sync_done = syncing && (cnt_q == CNT_ZERO);
  wire others_open = !lock_q && !ctrl_q.enable;
  wire take_others = wr_valid && others_open;
  wire wr_enable = wr_data.enable;
  wire core_on = (state_q == ACC_CH_ON);
  wire single_mode = (ctrl_q.single == ACC_MODE_SINGLE);
  wire start_ok = core_on && single_mode && meas_start && !armed_q;

  // Register image: enable always lands at once, other bits only when open.
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_valid)
    begin
      ctrl_d.enable = wr_enable;
    end
    if (take_others)
    begin
      ctrl_d.single = wr_data.single;
      ctrl_d.aux = wr_data.aux;
    end
    ctrl_d.reserved0 = 1'b0;
  end

  // Channel sequencer: each write restarts the delay toward the new value.
  // A write landing in the completion cycle wins, so pending never drops
  // while a newer value is still on its way to the core.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pending_d = pending_q;
    core_en_d = core_en_q;
    lock_d = lock_q;
    case (state_q)
      ACC_CH_OFF,
      ACC_CH_ON:
      begin
        state_d = state_q;
      end
      ACC_CH_SYNC_ON:
      begin
        if (sync_done)
        begin
          state_d = ACC_CH_ON;
          core_en_d = 1'b1;
          pending_d = 1'b0;
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ACC_CH_SYNC_OFF:
      begin
        if (sync_done)
        begin
          state_d = ACC_CH_OFF;
          core_en_d = 1'b0;
          pending_d = 1'b0;
          lock_d = 1'b0;
        end
        else
        begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default:
      begin
        state_d = ACC_CH_OFF;
        core_en_d = 1'b0;
      end
    endcase
    if (wr_valid)
    begin
      state_d = wr_enable ? ACC_CH_SYNC_ON : ACC_CH_SYNC_OFF;
      cnt_d = CNT_LAST;
      pending_d = 1'b1;
      if (wr_enable)
      begin
        lock_d = 1'b1;
      end
    end
  end

  // Measurement: continuous mode tracks the pin, one-shot takes one sample
  // per start request, and nothing is measured while the core is off.
  always_comb
  begin
    armed_d = armed_q;
    result_d = result_q;
    result_d.valid = 1'b0;
    if (!core_on)
    begin
      armed_d = 1'b0;
    end
    else if (!single_mode)
    begin
      armed_d = 1'b0;
      if (cmp_level != result_q.level)
      begin
        result_d.level = cmp_level;
        result_d.valid = 1'b1;
      end
    end
    else if (armed_q)
    begin
      armed_d = 1'b0;
      result_d.level = cmp_level;
      result_d.valid = 1'b1;
    end
    else if (start_ok)
    begin
      armed_d = 1'b1;
    end
  end

  // State registers; everything comes up disabled and unlocked.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= ACC_CTRL_RESET;
      state_q <= ACC_CH_OFF;
      cnt_q <= CNT_ZERO;
      pending_q <= 1'b0;
      lock_q <= 1'b0;
      core_en_q <= 1'b0;
      armed_q <= 1'b0;
      result_q <= ACC_RESULT_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      pending_q <= pending_d;
      lock_q <= lock_d;
      core_en_q <= core_en_d;
      armed_q <= armed_d;
      result_q <= result_d;
    end
  end

  // All outputs are flip-flop values; single and aux reach the core directly
  // because they are frozen while the core runs.
  assign channel_control_reg = ctrl_q;
  assign sync_pending_flags = pending_q;
  assign comp_enable = core_en_q;
  assign comp_single = ctrl_q.single;
  assign comp_aux = ctrl_q.aux;
  assign comp_result = result_q;

endmodule

`default_nettype wire

// *** rtl/acc_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module acc_pin_sync
  import acc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // One three-stage chain per bit; the settled level moves only when the
  // second and third stages agree, so a single metastable sample is ignored.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      logic [ACC_PIN_STAGES-1:0] stage_q;
      logic level_q;
      wire agree = (stage_q[1] == stage_q[2]);

      // The first stage feeds only the second stage.
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          stage_q <= '0;
          level_q <= 1'b0;
        end
        else
        begin
          stage_q <= {stage_q[1:0], pin_in[gi]};
          if (agree)
          begin
            level_q <= stage_q[2];
          end
        end
      end

      assign level_out[gi] = level_q;
    end
  endgenerate

endmodule

`default_nettype wire

// *** rtl/acc_pkg.sv ***
`default_nettype none

package acc_pkg;

  // Width of the further control bits that share the channel control register.
  localparam int ACC_AUX_W = 4;

  // Bit positions inside the channel control register.
  localparam int ACC_ENABLE_POS = 1;
  localparam int ACC_SINGLE_POS = 2;
  localparam int ACC_AUX_POS = 3;

  // Encoding of the measurement style bit.
  localparam logic ACC_MODE_CONTINUOUS = 1'b0;
  localparam logic ACC_MODE_SINGLE = 1'b1;

  // Cycles from an enable write until the comparator core follows it.
  localparam int ACC_SYNC_CYCLES = 4;

  // Flip-flops in the chain that brings the comparator pin into sys_clk.
  localparam int ACC_PIN_STAGES = 3;

  // Channel control register image; bit 0 is reserved and reads as zero.
  typedef struct packed {
    logic [ACC_AUX_W-1:0] aux;
    logic single;
    logic enable;
    logic reserved0;
  } acc_ctrl_t;

  localparam int ACC_CTRL_W = ACC_AUX_W + 3;
  localparam acc_ctrl_t ACC_CTRL_RESET = acc_ctrl_t'(7'h00);

  // Comparator result as handed to the user side.
  typedef struct packed {
    logic level;
    logic valid;
  } acc_result_t;

  localparam acc_result_t ACC_RESULT_RESET = acc_result_t'(2'h0);

  // Channel states as seen by the comparator core.
  typedef enum logic [1:0] {
    ACC_CH_OFF = 2'b00,
    ACC_CH_SYNC_ON = 2'b01,
    ACC_CH_ON = 2'b10,
    ACC_CH_SYNC_OFF = 2'b11
  } acc_ch_state_t;

endpackage

`default_nettype wire
